// file: rtl/ppm_pkg.sv
// Constants and types shared by the parallel port mode control block
package ppm_pkg;
    // ****************************************
    // Register map (byte addresses, 32-bit words)
    // ****************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFS_STROBE_CNT = 8'h00;
    localparam logic [7:0] OFS_PORT_MODE = 8'h04;
    localparam logic [7:0] OFS_PORT_DATA = 8'h08;
    localparam logic [7:0] OFS_PORT_ADDR = 8'h0C;
    localparam logic [7:0] OFS_PORT_STATUS = 8'h10;
    localparam logic [7:0] OFS_SW_CONTROL = 8'h14;

    // ****************************************
    // Field positions and reset values
    // ****************************************
    localparam int MODE_LO = 0;
    localparam int NIB_SEL_BIT = 2;
    localparam int DIR_BIT = 3;
    localparam int GIN_LATCH_BIT = 5;
    localparam int PORT_EN_BIT = 7;
    localparam int STA_RXF_BIT = 0;
    localparam int STA_TXE_BIT = 1;
    localparam int STA_XFER_BIT = 2;
    localparam int STA_LINES_LO = 3;
    localparam logic [7:0] CNT_RST = 8'h12;
    localparam logic GIN_LATCH_RST = 1'b1;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_NS = 20;
    localparam int TICK_NS = 40;
    localparam int TICK_CYC = (TICK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] TICK_LAST = 4'(TICK_CYC - 1);

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        MODE_LEGACY = 2'b00,
        MODE_SPP = 2'b01,
        MODE_EPP = 2'b10,
        MODE_ECP = 2'b11
    } ppm_mode_e;

    typedef enum logic [2:0] {
        XF_IDLE = 3'b000,
        XF_WAIT_BUSY = 3'b001,
        XF_DELAY = 3'b011,
        XF_PULSE = 3'b010,
        XF_DONE = 3'b110
    } ppm_xfer_e;
endpackage

// file: rtl/ppm_sync.sv
// Two-stage synchroniser bank for pin inputs
`timescale 1ns/1ps
`default_nettype none
module ppm_sync #(
    parameter int W = 8
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // Data
    input wire logic [W-1:0] din,
    output logic [W-1:0] dout
);
    typedef struct packed {
        logic [W-1:0] meta;
        logic [W-1:0] stable;
    } ppm_sync_s;

    ppm_sync_s st;
    ppm_sync_s next_st;

    always_comb begin
        next_st.meta = din;
        next_st.stable = st.meta;
        if (sys_rst) begin
            next_st = '0;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    assign dout = st.stable;
endmodule
`default_nettype wire

// file: rtl/ppm_port_ctrl.sv
// Parallel port mode control: AXI4-Lite registers, line ownership, strobe timing
// ****************************************
// ****************************************
`timescale 1ns/1ps
`default_nettype none
module ppm_port_ctrl (
    // Clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // AXI4-Lite write address and data
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Parallel data lines (two-way)
    input wire logic [7:0] parallel_data_lines_in,
    output logic [7:0] parallel_data_lines_out,
    output logic parallel_data_lines_oe,
    // Host-driven control lines, [0] SLIN/ASTRB, [1] STB/WRITE/HOSTCLK,
    // [2] AFD/DSTRB/HOSTACK, [3] INIT/REVREQ
    output logic [3:0] host_ctl,
    // Peripheral lines, [0] ACK/INTR/PERIPCLK, [1] FALT/PERIPREQ, [2] SLCT,
    // [3] PER/MPRIPREQ, [4] BUSY/WAIT/PERIPHACK
    input wire logic [4:0] periph_ctl
);
    typedef struct packed {
        logic awready;
        logic aw_got;
        logic [7:0] aw_addr;
        logic wready;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [7:0] strobe_cnt;
        logic port_en;
        logic gin_latch;
        logic dir;
        logic nib_sel;
        ppm_pkg::ppm_mode_e mode;
        logic [7:0] data;
        logic [7:0] addr;
        logic [3:0] sw_ctl;
        logic tx_empty;
        logic tx_is_addr;
        logic rx_full;
        logic nib_half;
        logic ack_prev;
        logic [3:0] div;
        ppm_pkg::ppm_xfer_e fsm;
        logic [7:0] run_cnt;
        logic strobe_on;
        logic [7:0] line_out;
        logic line_oe;
        logic [3:0] ctl;
    } ppm_state_s;

    ppm_state_s st;
    ppm_state_s next_st;
    logic [7:0] lines_s;
    logic [4:0] pctl_s;

    // ****************************************
    // Pin synchronisers
    // ****************************************
    ppm_sync #(.W(8)) u_sync_lines (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(parallel_data_lines_in),
        .dout(lines_s)
    );

    ppm_sync #(.W(5)) u_sync_ctl (
        .mclk(mclk),
        .sys_rst(sys_rst),
        .din(periph_ctl),
        .dout(pctl_s)
    );

    // ****************************************
    // Next-state logic
    // ****************************************
    logic active;
    logic auto_mode;
    logic out_dir;
    logic tick;
    logic do_write;
    logic wr_lo;
    logic do_read;
    logic rd_hit;
    logic [31:0] rd_val;
    logic ack_rise;

    always_comb begin
        next_st = st;
        active = st.port_en && !st.gin_latch;
        auto_mode = st.mode != ppm_pkg::MODE_LEGACY;
        out_dir = !auto_mode || !st.dir;
        tick = st.div == ppm_pkg::TICK_LAST;
        do_write = st.aw_got && st.w_got && !st.bvalid;
        wr_lo = st.w_strb[0];
        do_read = s_axi_arvalid && st.arready;
        rd_hit = 1'b1;
        rd_val = '0;
        ack_rise = pctl_s[0] && !st.ack_prev;
        next_st.ack_prev = pctl_s[0];
        next_st.div = tick ? 4'h0 : st.div + 4'h1;

        // Write channel handshakes, either order
        if (s_axi_awvalid && st.awready) begin
            next_st.aw_got = 1'b1;
            next_st.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && st.wready) begin
            next_st.w_got = 1'b1;
            next_st.w_data = s_axi_wdata;
            next_st.w_strb = s_axi_wstrb;
        end
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        if (do_write) begin
            next_st.aw_got = 1'b0;
            next_st.w_got = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = ppm_pkg::RESP_OKAY;
            case (st.aw_addr)
                ppm_pkg::OFS_STROBE_CNT: begin
                    if (wr_lo) begin
                        next_st.strobe_cnt = st.w_data[7:0];
                    end
                end
                ppm_pkg::OFS_PORT_MODE: begin
                    if (wr_lo) begin
                        next_st.mode = ppm_pkg::ppm_mode_e'(st.w_data[ppm_pkg::MODE_LO +: 2]);
                        next_st.nib_sel = st.w_data[ppm_pkg::NIB_SEL_BIT];
                        next_st.dir = st.w_data[ppm_pkg::DIR_BIT];
                        next_st.gin_latch = st.w_data[ppm_pkg::GIN_LATCH_BIT];
                        next_st.port_en = st.w_data[ppm_pkg::PORT_EN_BIT];
                    end
                end
                ppm_pkg::OFS_PORT_DATA: begin
                    // Refused while a byte is still pending or the port is off
                    if (wr_lo && st.tx_empty && active && out_dir) begin
                        next_st.data = st.w_data[7:0];
                        next_st.tx_empty = !auto_mode;
                        next_st.tx_is_addr = 1'b0;
                    end
                end
                ppm_pkg::OFS_PORT_ADDR: begin
                    // Address cycles exist only in EPP and ECP
                    if (wr_lo && st.tx_empty && active && out_dir &&
                        (st.mode == ppm_pkg::MODE_EPP || st.mode == ppm_pkg::MODE_ECP)) begin
                        next_st.addr = st.w_data[7:0];
                        next_st.tx_empty = 1'b0;
                        next_st.tx_is_addr = 1'b1;
                    end
                end
                ppm_pkg::OFS_SW_CONTROL: begin
                    if (wr_lo) begin
                        next_st.sw_ctl = st.w_data[3:0];
                    end
                end
                ppm_pkg::OFS_PORT_STATUS: begin
                end
                default: begin
                    next_st.bresp = ppm_pkg::RESP_SLVERR;
                end
            endcase
        end

        // Read channel
        case (s_axi_araddr)
            ppm_pkg::OFS_STROBE_CNT: rd_val = {24'h00_0000, st.strobe_cnt};
            ppm_pkg::OFS_PORT_MODE: rd_val = {24'h00_0000, st.port_en, 1'b0, st.gin_latch, 1'b0,
                                              st.dir, st.nib_sel, st.mode};
            ppm_pkg::OFS_PORT_DATA: rd_val = {24'h00_0000, st.data};
            ppm_pkg::OFS_PORT_ADDR: rd_val = {24'h00_0000, st.addr};
            ppm_pkg::OFS_PORT_STATUS: rd_val = {24'h00_0000, pctl_s,
                                                st.fsm != ppm_pkg::XF_IDLE,
                                                st.tx_empty, st.rx_full};
            ppm_pkg::OFS_SW_CONTROL: rd_val = {28'h000_0000, st.sw_ctl};
            default: rd_hit = 1'b0;
        endcase
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (do_read) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_val;
            next_st.rresp = rd_hit ? ppm_pkg::RESP_OKAY : ppm_pkg::RESP_SLVERR;
            // Clear first so a capture in the same cycle still sets the flag
            if (s_axi_araddr == ppm_pkg::OFS_PORT_DATA) begin
                next_st.rx_full = 1'b0;
            end
        end

        // Reverse direction capture on each rising ACK
        if (active && auto_mode && st.dir && ack_rise) begin
            if (st.mode == ppm_pkg::MODE_SPP && st.nib_sel) begin
                if (!st.nib_half) begin
                    next_st.data[3:0] = lines_s[3:0];
                    next_st.nib_half = 1'b1;
                end else begin
                    next_st.data[7:4] = lines_s[3:0];
                    next_st.nib_half = 1'b0;
                    next_st.rx_full = 1'b1;
                end
            end else begin
                next_st.data = lines_s;
                next_st.rx_full = 1'b1;
            end
        end
        if (st.gin_latch) begin
            next_st.data = lines_s;
        end

        // Forward strobe sequencer
        case (st.fsm)
            ppm_pkg::XF_IDLE: begin
                if (active && auto_mode && out_dir && !st.tx_empty) begin
                    next_st.fsm = ppm_pkg::XF_WAIT_BUSY;
                end
            end
            ppm_pkg::XF_WAIT_BUSY: begin
                if (pctl_s[4]) begin
                    next_st.run_cnt = st.strobe_cnt;
                    next_st.fsm = ppm_pkg::XF_DELAY;
                end
            end
            ppm_pkg::XF_DELAY: begin
                if (st.run_cnt == 8'h00) begin
                    next_st.strobe_on = 1'b1;
                    next_st.run_cnt = st.strobe_cnt;
                    next_st.fsm = ppm_pkg::XF_PULSE;
                end else if (tick) begin
                    next_st.run_cnt = st.run_cnt - 8'h01;
                end
            end
            ppm_pkg::XF_PULSE: begin
                if (st.run_cnt == 8'h00) begin
                    next_st.strobe_on = 1'b0;
                    next_st.fsm = ppm_pkg::XF_DONE;
                end else if (tick) begin
                    next_st.run_cnt = st.run_cnt - 8'h01;
                end
            end
            ppm_pkg::XF_DONE: begin
                next_st.tx_empty = 1'b1;
                next_st.fsm = ppm_pkg::XF_IDLE;
            end
            default: begin
                next_st.fsm = ppm_pkg::XF_IDLE;
            end
        endcase
        // Dropping enable aborts and discards the pending byte
        if (!active) begin
            next_st.fsm = ppm_pkg::XF_IDLE;
            next_st.strobe_on = 1'b0;
            next_st.tx_empty = 1'b1;
        end

        // Line ownership per mode
        next_st.line_out = st.tx_is_addr ? st.addr : st.data;
        next_st.line_oe = active && out_dir;
        next_st.ctl = st.sw_ctl;
        case (st.mode)
            ppm_pkg::MODE_SPP: begin
                next_st.ctl[1] = st.strobe_on;
            end
            ppm_pkg::MODE_EPP: begin
                next_st.ctl[0] = st.strobe_on && st.tx_is_addr;
                next_st.ctl[1] = st.fsm != ppm_pkg::XF_IDLE;
                next_st.ctl[2] = st.strobe_on && !st.tx_is_addr;
            end
            ppm_pkg::MODE_ECP: begin
                next_st.ctl[1] = st.strobe_on;
                next_st.ctl[2] = !st.tx_is_addr;
                next_st.ctl[3] = st.dir;
            end
            default: begin
            end
        endcase

        next_st.awready = !next_st.aw_got && !next_st.bvalid;
        next_st.wready = !next_st.w_got && !next_st.bvalid;
        next_st.arready = !next_st.rvalid;

        if (sys_rst) begin
            next_st = '0;
            next_st.strobe_cnt = ppm_pkg::CNT_RST;
            next_st.mode = ppm_pkg::MODE_LEGACY;
            next_st.gin_latch = ppm_pkg::GIN_LATCH_RST;
            next_st.tx_empty = 1'b1;
        end
    end

    always_ff @(posedge mclk) begin
        st <= next_st;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign s_axi_awready = st.awready;
    assign s_axi_wready = st.wready;
    assign s_axi_bresp = st.bresp;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_arready = st.arready;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign s_axi_rvalid = st.rvalid;
    assign parallel_data_lines_out = st.line_out;
    assign parallel_data_lines_oe = st.line_oe;
    assign host_ctl = st.ctl;

    // ****************************************
    // Checks
    // ****************************************
    logic [9:0] hlp_cyc;

    always_ff @(posedge mclk) begin
        if (sys_rst || st.fsm != next_st.fsm) begin
            hlp_cyc <= 10'h000;
        end else begin
            hlp_cyc <= hlp_cyc + 10'h001;
        end
    end

    chk_cnt_reset: assert property (@(posedge mclk) $fell(sys_rst) |->
        st.strobe_cnt == ppm_pkg::CNT_RST && st.mode == ppm_pkg::MODE_LEGACY && !st.port_en)
        else $error("Strobe counter or mode wrong after reset");
    chk_gpi_capture: assert property (@(posedge mclk) disable iff (sys_rst)
        st.gin_latch |=> st.data == $past(lines_s))
        else $error("Data register missed the data lines");
    chk_gpi_input: assert property (@(posedge mclk) disable iff (sys_rst)
        st.gin_latch |=> !parallel_data_lines_oe)
        else $error("Data lines driven while general input is on");
    chk_enable_block: assert property (@(posedge mclk) disable iff (sys_rst)
        !st.port_en |=> st.fsm == ppm_pkg::XF_IDLE ##1
        (!host_ctl[1] || st.mode == ppm_pkg::MODE_LEGACY))
        else $error("Transfer ran with the port disabled");
    chk_legacy_out: assert property (@(posedge mclk) disable iff (sys_rst)
        st.mode == ppm_pkg::MODE_LEGACY && active |=> parallel_data_lines_oe &&
        host_ctl == $past(st.sw_ctl))
        else $error("Legacy mode is not software driven output");
    chk_xfer_start: assert property (@(posedge mclk) disable iff (sys_rst)
        st.fsm == ppm_pkg::XF_IDLE && active && auto_mode && out_dir && !st.tx_empty |=>
        st.fsm == ppm_pkg::XF_WAIT_BUSY)
        else $error("Pending byte did not start a transfer");
    chk_delay_len: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(st.fsm) == ppm_pkg::XF_DELAY && st.fsm == ppm_pkg::XF_PULSE |->
        $past(hlp_cyc) + 10'h001 >= {1'b0, st.strobe_cnt, 1'b0} &&
        $past(hlp_cyc) <= {1'b0, st.strobe_cnt, 1'b0} + 10'h001)
        else $error("Delay before strobe has the wrong length");
    chk_pulse_len: assert property (@(posedge mclk) disable iff (sys_rst)
        $past(st.fsm) == ppm_pkg::XF_PULSE && st.fsm == ppm_pkg::XF_DONE |->
        $past(hlp_cyc) + 10'h001 >= {1'b0, st.strobe_cnt, 1'b0} &&
        $past(hlp_cyc) <= {1'b0, st.strobe_cnt, 1'b0} + 10'h001)
        else $error("Strobe pulse has the wrong width");
    chk_nibble_spp: assert property (@(posedge mclk) disable iff (sys_rst)
        $changed(st.nib_half) |-> $past(st.mode) == ppm_pkg::MODE_SPP && $past(st.nib_sel))
        else $error("Nibble sequencing outside SPP nibble mode");
    chk_rx_store: assert property (@(posedge mclk) disable iff (sys_rst)
        active && auto_mode && st.dir && !(st.mode == ppm_pkg::MODE_SPP && st.nib_sel) &&
        ack_rise |=> st.rx_full && st.data == $past(lines_s))
        else $error("Received byte not stored");

    cov_fwd_done: cover property (@(posedge mclk) disable iff (sys_rst)
        st.fsm == ppm_pkg::XF_PULSE ##[1:600] st.fsm == ppm_pkg::XF_DONE);
    cov_nibble: cover property (@(posedge mclk) disable iff (sys_rst)
        st.nib_half ##[1:200] st.rx_full);
    cov_abort: cover property (@(posedge mclk) disable iff (sys_rst)
        st.fsm == ppm_pkg::XF_DELAY && !st.port_en);
endmodule
`default_nettype wire

// file: tb/ppm_periph_model.sv
// Behavioural peripheral on the far side of the parallel port
`timescale 1ns/1ps
`default_nettype none
module ppm_periph_model (
    // Clock
    input wire logic mclk,
    // Bench commands
    input wire logic busy_on,
    input wire logic send_go,
    input wire logic [7:0] send_byte,
    output logic send_done,
    // Port lines
    input wire logic [7:0] host_byte,
    input wire logic host_oe,
    output logic [7:0] line_bus,
    output logic [4:0] periph_ctl
);
    // ****************************************
    // Line drive and handshake
    // ****************************************
    logic [3:0] cnt = 4'h0;
    logic [7:0] last = 8'h00;
    logic drv;
    assign drv = send_go || cnt != 4'h0;
    // No pull on the data lines: a released bus must not look like the old byte
    assign line_bus = host_oe ? host_byte : (drv ? send_byte : ~last);
    assign periph_ctl = {busy_on, 3'b000, cnt >= 4'h4 && cnt < 4'h8};
    assign send_done = cnt == 4'hC;
    always @(posedge mclk) begin
        // Remember only driven bytes so a released bus stays steady
        if (host_oe || drv) begin
            last <= line_bus;
        end
        if (send_go && cnt != 4'hC) begin
            cnt <= cnt + 4'h1;
        end else if (!send_go) begin
            cnt <= 4'h0;
        end
    end
endmodule
`default_nettype wire

// file: tb/parallel_port_mode_control_bench.sv
// Self-checking bench for the parallel port mode control block
`timescale 1ns/1ps
`default_nettype none
module parallel_port_mode_control_bench;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00, send_byte = 8'h00, rd, line_bus;
    logic [7:0] line_out;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, busy_on = 1'b0, send_go = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic line_oe, send_done;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr, wr;
    logic [3:0] host_ctl;
    logic [4:0] periph_ctl;
    int err_count = 0, tests_run = 0, cyc = 0;

    always #10 mclk = ~mclk;

    ppm_port_ctrl dut_u (.mclk(mclk), .sys_rst(sys_rst), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
        .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
        .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
        .parallel_data_lines_in(line_bus), .parallel_data_lines_out(line_out),
        .parallel_data_lines_oe(line_oe), .host_ctl(host_ctl), .periph_ctl(periph_ctl));

    ppm_periph_model model_u (.mclk(mclk), .busy_on(busy_on), .send_go(send_go),
        .send_byte(send_byte), .send_done(send_done), .host_byte(line_out), .host_oe(line_oe),
        .line_bus(line_bus), .periph_ctl(periph_ctl));

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        tests_run++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 30000) begin
            err_count++;
            close_out;
        end
    end

    task automatic axi_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h00_0000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (!s_axi_bvalid);
        wr = s_axi_bresp;
        s_axi_bready <= 1'b0;
        repeat (2) @(posedge mclk);
    endtask

    task automatic axi_rd(input logic [7:0] a);
        @(posedge mclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do begin
            @(posedge mclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
        end while (!s_axi_rvalid);
        rd = s_axi_rdata[7:0];
        rr = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    task automatic send(input logic [7:0] b);
        send_byte <= b;
        send_go <= 1'b1;
        do @(posedge mclk); while (!send_done);
        send_go <= 1'b0;
        repeat (3) @(posedge mclk);
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs;
        axi_rd(ppm_pkg::OFS_STROBE_CNT);
        chk("counter reset", 8'h12, rd);
        axi_rd(ppm_pkg::OFS_PORT_MODE);
        chk("mode reset", 8'h20, rd);
        axi_rd(8'h18);
        chk("unmapped resp", {6'h00, ppm_pkg::RESP_SLVERR}, {6'h00, rr});
        axi_wr(8'h18, 8'h00);
        chk("unmapped wresp", {6'h00, ppm_pkg::RESP_SLVERR}, {6'h00, wr});
        axi_wr(ppm_pkg::OFS_STROBE_CNT, 8'hA5);
        chk("write resp", {6'h00, ppm_pkg::RESP_OKAY}, {6'h00, wr});
        axi_rd(ppm_pkg::OFS_STROBE_CNT);
        chk("counter rw", 8'hA5, rd);
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'hFF);
        axi_rd(ppm_pkg::OFS_PORT_MODE);
        chk("mode readback", 8'hAF, rd);
        chk("input mode", 8'h00, 8'(line_oe));
    endtask

    task automatic t_forward;
        logic [1:0] m;
        logic [7:0] ofs, n;
        int sb, d, w;
        for (int i = 0; i < 5; i++) begin
            m = i == 0 ? ppm_pkg::MODE_SPP : (i < 3 ? ppm_pkg::MODE_EPP : ppm_pkg::MODE_ECP);
            ofs = (i == 2 || i == 4) ? ppm_pkg::OFS_PORT_ADDR : ppm_pkg::OFS_PORT_DATA;
            sb = i == 1 ? 2 : (i == 2 ? 0 : 1);
            n = 8'(i + 1);
            axi_wr(ppm_pkg::OFS_STROBE_CNT, n);
            axi_wr(ppm_pkg::OFS_PORT_MODE, {6'b10_0000, m});
            axi_wr(ofs, 8'(8'h31 + i));
            repeat (20) @(posedge mclk);
            chk("strobe before busy", 8'h00, 8'(host_ctl[sb]));
            busy_on <= 1'b1;
            d = 0;
            while (!host_ctl[sb] && d < 600) begin
                @(posedge mclk);
                d++;
            end
            w = 0;
            while (host_ctl[sb] && w < 600) begin
                @(posedge mclk);
                w++;
            end
            chk("strobe delay", 8'h01, 8'(d >= 2 * n + 2 && d <= 2 * n + 8));
            chk("strobe width", 8'(2 * n), 8'(w));
            chk("data lines", 8'(8'h31 + i), line_out);
            busy_on <= 1'b0;
            axi_rd(ppm_pkg::OFS_PORT_STATUS);
            chk("tx empty", 8'h01, 8'(rd[ppm_pkg::STA_TXE_BIT]));
        end
    endtask

    task automatic t_legacy;
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'h88);
        chk("legacy drives", 8'h01, 8'(line_oe));
        axi_wr(ppm_pkg::OFS_PORT_DATA, 8'h5A);
        chk("legacy data", 8'h5A, line_out);
        axi_wr(ppm_pkg::OFS_SW_CONTROL, 8'h09);
        chk("legacy control", 8'h09, 8'(host_ctl));
    endtask

    task automatic t_reverse;
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'h89);
        send(8'h96);
        axi_rd(ppm_pkg::OFS_PORT_STATUS);
        chk("rx full", 8'h01, 8'(rd[ppm_pkg::STA_RXF_BIT]));
        axi_rd(ppm_pkg::OFS_PORT_DATA);
        chk("rx byte", 8'h96, rd);
        axi_rd(ppm_pkg::OFS_PORT_STATUS);
        chk("rx cleared", 8'h00, 8'(rd[ppm_pkg::STA_RXF_BIT]));
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'h8D);
        send(8'hF7);
        send(8'h0C);
        axi_rd(ppm_pkg::OFS_PORT_DATA);
        chk("nibble pair", 8'hC7, rd);
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'h8E);
        send(8'hE1);
        axi_rd(ppm_pkg::OFS_PORT_DATA);
        chk("nibble ignored", 8'hE1, rd);
    endtask

    task automatic t_latch;
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'hA1);
        chk("latch input", 8'h00, 8'(line_oe));
        send_byte <= 8'h3C;
        send_go <= 1'b1;
        repeat (6) @(posedge mclk);
        axi_rd(ppm_pkg::OFS_PORT_DATA);
        chk("latched byte", 8'h3C, rd);
        send_go <= 1'b0;
    endtask

    task automatic t_disable;
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'h01);
        axi_wr(ppm_pkg::OFS_PORT_DATA, 8'h77);
        chk("disabled drive", 8'h00, 8'(line_oe));
        axi_rd(ppm_pkg::OFS_PORT_STATUS);
        chk("disabled idle", 8'h00, 8'(rd[ppm_pkg::STA_XFER_BIT]));
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'h81);
        axi_wr(ppm_pkg::OFS_PORT_DATA, 8'h66);
        axi_rd(ppm_pkg::OFS_PORT_STATUS);
        chk("xfer pending", 8'h01, 8'(rd[ppm_pkg::STA_XFER_BIT]));
        axi_wr(ppm_pkg::OFS_PORT_MODE, 8'h01);
        axi_rd(ppm_pkg::OFS_PORT_STATUS);
        chk("abort empty", 8'h01, 8'(rd[ppm_pkg::STA_TXE_BIT]));
        chk("abort idle", 8'h00, 8'(rd[ppm_pkg::STA_XFER_BIT]));
    endtask

    initial begin
        repeat (5) @(posedge mclk);
        sys_rst <= 1'b0;
        t_regs;
        t_forward;
        t_legacy;
        t_reverse;
        t_latch;
        t_disable;
        close_out;
    end
endmodule
`default_nettype wire
